/* File: verilog/bcr_pkg.sv */
/*
 Package for the buck channel configuration register bank: offsets,
 field positions, reset values, timing figures and carrier structs.
 Assumes a single 10 MHz system clock.
*/
`default_nettype none
package bcr_pkg;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] BCR_OFF_CH23_VOLT   = 8'h03;
   localparam logic [7:0] BCR_OFF_CH4_VOLT    = 8'h04;
   localparam logic [7:0] BCR_OFF_SCALING     = 8'h05;
   localparam logic [7:0] BCR_OFF_MODE_DSCG   = 8'h06;
   localparam logic [7:0] BCR_OFF_LATCHOFF    = 8'h07;
   localparam logic [7:0] BCR_OFF_FREQ_PHASE  = 8'h08;
   localparam logic [7:0] BCR_OFF_HICCUP_SYNC = 8'h0a;
   localparam logic [7:0] BCR_OFF_LATCH_STAT  = 8'h0c;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int BCR_CH2_VOLT_LSB   = 0;
   localparam int BCR_CH4_VOLT_LSB   = 0;
   localparam int BCR_CH1_INTVAL_LSB = 0;
   localparam int BCR_CH1_SCALE_BIT  = 2;
   localparam int BCR_CH4_INTVAL_LSB = 4;
   localparam int BCR_CH4_SCALE_BIT  = 6;
   localparam int BCR_PSAVE_LSB      = 0;
   localparam int BCR_DSCG_LSB       = 4;
   localparam int BCR_SHORT_LSB      = 0;
   localparam int BCR_OVER_LSB       = 4;
   localparam int BCR_PH2_LSB        = 0;
   localparam int BCR_PH3_LSB        = 2;
   localparam int BCR_PH4_LSB        = 4;
   localparam int BCR_CH1_HALF_BIT   = 6;
   localparam int BCR_CH3_HALF_BIT   = 7;
   localparam int BCR_SYNC_OUT_BIT   = 7;

   // ----------------------------------------------------------------
   // Fixed reset values
   // ----------------------------------------------------------------
   localparam logic [1:0] BCR_RST_INTVAL  = 2'h0;
   localparam logic       BCR_RST_SCALE   = 1'h0;
   localparam logic [3:0] BCR_RST_PSAVE   = 4'h0;
   localparam logic [1:0] BCR_RST_PH2     = 2'h2;
   localparam logic [1:0] BCR_RST_PH3     = 2'h0;
   localparam logic [1:0] BCR_RST_PH4     = 2'h2;
   localparam logic [3:0] BCR_RST_LATCH   = 4'h0;
   localparam logic [7:0] BCR_DATA_ZERO   = 8'h00;

   // ----------------------------------------------------------------
   // Scaling step intervals, ns, and their cycle counts at 10 MHz
   // ----------------------------------------------------------------
   localparam int BCR_CLK_PERIOD_NS = 100;
   localparam int BCR_STEP0_NS      = 62500;
   localparam int BCR_STEP1_NS      = 31200;
   localparam int BCR_STEP2_NS      = 15600;
   localparam int BCR_STEP3_NS      = 7800;
   localparam int BCR_STEP0_CYC = BCR_STEP0_NS / BCR_CLK_PERIOD_NS;
   localparam int BCR_STEP1_CYC = BCR_STEP1_NS / BCR_CLK_PERIOD_NS;
   localparam int BCR_STEP2_CYC = BCR_STEP2_NS / BCR_CLK_PERIOD_NS;
   localparam int BCR_STEP3_CYC = BCR_STEP3_NS / BCR_CLK_PERIOD_NS;
   localparam int BCR_STEP_W    = 10;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   // Factory fuse defaults
   typedef struct packed {
      logic [2:0] ch2_volt_code;
      logic [4:0] ch4_volt_code;
      logic [3:0] discharge_enable;
      logic [3:0] overvoltage_latchoff_enable;
      logic [3:0] short_latchoff_enable;
      logic       ch3_half_freq;
      logic       ch1_half_freq;
      logic       sync_output_select;
   } bcr_fuse_t;

   // Register port access
   typedef struct packed {
      logic       wr_strobe;
      logic       rd_strobe;
      logic [7:0] addr;
      logic [7:0] wdata;
   } bcr_req_t;

   // Effective settings driven to the regulator
   typedef struct packed {
      logic [2:0] ch2_volt_code;
      logic [4:0] ch4_volt_code;
      logic       ch1_scaling_enable;
      logic       ch4_scaling_enable;
      logic [3:0] power_save_active;
      logic [3:0] discharge_enable;
      logic [3:0] overvoltage_latchoff_enable;
      logic [3:0] short_latchoff_enable;
      logic       ch3_half_freq;
      logic       ch1_half_freq;
      logic [1:0] ch2_phase_offset;
      logic [1:0] ch3_phase_offset;
      logic [1:0] ch4_phase_offset;
      logic       sync_output_select;
   } bcr_cfg_t;

   // Step interval code to cycle count
   function automatic logic [BCR_STEP_W-1:0] bcr_step_cycles
      (input logic [1:0] code);
      unique case (code)
         2'h0: bcr_step_cycles = BCR_STEP_W'(BCR_STEP0_CYC);
         2'h1: bcr_step_cycles = BCR_STEP_W'(BCR_STEP1_CYC);
         2'h2: bcr_step_cycles = BCR_STEP_W'(BCR_STEP2_CYC);
         2'h3: bcr_step_cycles = BCR_STEP_W'(BCR_STEP3_CYC);
      endcase
   endfunction : bcr_step_cycles

endpackage : bcr_pkg
`default_nettype wire

/* File: verilog/bcr_step_timer.sv */
/*
 Scaling step tick generator for one channel.
 Assumes synchronous active-high reset and the 10 MHz system clock.
*/
`timescale 1ns/1ps
`default_nettype none
module bcr_step_timer
   import bcr_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_sys_in,
   input  wire logic       reset_in,
   // Control
   input  wire logic       enable_in,
   input  wire logic [1:0] interval_in,
   // Tick
   output logic            step_tick_out
);

   logic [BCR_STEP_W-1:0] count_ff;
   logic [BCR_STEP_W-1:0] nxt_count;
   logic                  tick_ff;
   logic                  nxt_tick;

   // ----------------------------------------------------------------
   // Count down one step interval, pulse at the end
   // ----------------------------------------------------------------
   always_comb
   begin
      nxt_count = count_ff;
      nxt_tick  = 1'b0;
      if (!enable_in)
      begin
         nxt_count = bcr_step_cycles(interval_in) - BCR_STEP_W'(1);
      end
      else if (count_ff == '0)
      begin
         nxt_count = bcr_step_cycles(interval_in) - BCR_STEP_W'(1);
         nxt_tick  = 1'b1;
      end
      else
      begin
         nxt_count = count_ff - BCR_STEP_W'(1);
      end
   end

   // Registers
   always_ff @(posedge clk_sys_in)
   begin
      if (reset_in)
      begin
         count_ff <= '0;
         tick_ff  <= 1'b0;
      end
      else
      begin
         count_ff <= nxt_count;
         tick_ff  <= nxt_tick;
      end
   end

   assign step_tick_out = tick_ff;

endmodule : bcr_step_timer
`default_nettype wire

/* File: verilog/bcr_latch_flags.sv */
/*
 Sticky per-channel latch-off flags with write-one-to-clear.
 Assumes fault inputs are synchronous to the system clock.
*/
`timescale 1ns/1ps
`default_nettype none
module bcr_latch_flags
   import bcr_pkg::*;
#(
   parameter int N_CH = 4
)
(
   // Clock and reset
   input  wire logic            clk_sys_in,
   input  wire logic            reset_in,
   // Faults and enables
   input  wire logic [N_CH-1:0] over_fault_in,
   input  wire logic [N_CH-1:0] short_fault_in,
   input  wire logic [N_CH-1:0] over_enable_in,
   input  wire logic [N_CH-1:0] short_enable_in,
   // Clear
   input  wire logic [N_CH-1:0] clear_in,
   // Flags
   output logic [N_CH-1:0]      flag_out
);

   logic [N_CH-1:0] flag_ff;
   logic [N_CH-1:0] nxt_flag;

   // ----------------------------------------------------------------
   // Set wins over clear; clear only once the fault is gone
   // ----------------------------------------------------------------
   always_comb
   begin
      nxt_flag = flag_ff;
      for (int i = 0; i < N_CH; i++)
      begin
         if ((over_enable_in[i] && over_fault_in[i]) ||
             (short_enable_in[i] && short_fault_in[i]))
            nxt_flag[i] = 1'b1;
         else if (clear_in[i])
            nxt_flag[i] = 1'b0;
      end
   end

   // Registers
   always_ff @(posedge clk_sys_in)
   begin
      if (reset_in)
         flag_ff <= '0;
      else
         flag_ff <= nxt_flag;
   end

   assign flag_out = flag_ff;

endmodule : bcr_latch_flags
`default_nettype wire

/* File: verilog/bcr_config_regs.sv */
/*
 Buck channel configuration register bank: holds channel 2 and 4
 voltage codes, scaling control, mode and discharge, latch-off
 enables, frequency and phase, and the latch-off status flags.
 Assumes a synchronous register port from the serial interface and
 that reset_in is the internal supply power-on reset, active high.
*/
`timescale 1ns/1ps
`default_nettype none
module bcr_config_regs
   import bcr_pkg::*;
#(
   parameter int N_CH = 4
)
(
   // Clock and power-on reset
   input  wire logic               clk_sys_in,
   input  wire logic               reset_in,
   // Factory fuse defaults
   input  wire bcr_pkg::bcr_fuse_t fuse_in,
   // Register port
   input  wire bcr_pkg::bcr_req_t  req_in,
   output logic [7:0]              rdata_out,
   output logic                    rvalid_out,
   // Mode pin level and fault sensing
   input  wire logic               mode_pin_in,
   input  wire logic [N_CH-1:0]    over_fault_in,
   input  wire logic [N_CH-1:0]    short_fault_in,
   // Settings to the regulator
   output bcr_pkg::bcr_cfg_t       cfg_out,
   output logic [N_CH-1:0]         latchoff_flag_out,
   output logic                    ch1_step_tick_out,
   output logic                    ch4_step_tick_out
);

   // ----------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------
   logic [7:0]      ch23_ff, nxt_ch23;
   logic [7:0]      ch4_ff, nxt_ch4;
   logic [7:0]      scale_ff, nxt_scale;
   logic [7:0]      mode_ff, nxt_mode;
   logic [7:0]      latch_ff, nxt_latch;
   logic [7:0]      freq_ff, nxt_freq;
   logic [7:0]      hiccup_ff, nxt_hiccup;
   logic [7:0]      rdata_ff, nxt_rdata;
   logic            rvalid_ff, nxt_rvalid;
   logic [N_CH-1:0] flag_clear;
   logic [N_CH-1:0] flags;
   logic [N_CH-1:0] psave_sel;
   logic            mode_bits_active;

   // Write decode helper
   function automatic logic wr_hit(input bcr_req_t r, input logic [7:0] a);
      wr_hit = r.wr_strobe && (r.addr == a);
   endfunction : wr_hit

   // ----------------------------------------------------------------
   // Reset values, fused fields from the fuse vector
   // ----------------------------------------------------------------
   logic [7:0] rst_ch23, rst_ch4, rst_scale, rst_mode;
   logic [7:0] rst_latch, rst_freq, rst_hiccup;

   always_comb
   begin
      rst_ch23   = BCR_DATA_ZERO;
      rst_ch23[BCR_CH2_VOLT_LSB +: 3] = fuse_in.ch2_volt_code;
      rst_ch4    = BCR_DATA_ZERO;
      rst_ch4[BCR_CH4_VOLT_LSB +: 5]  = fuse_in.ch4_volt_code;
      rst_scale  = BCR_DATA_ZERO;
      rst_scale[BCR_CH1_INTVAL_LSB +: 2] = BCR_RST_INTVAL;
      rst_scale[BCR_CH1_SCALE_BIT]       = BCR_RST_SCALE;
      rst_scale[BCR_CH4_INTVAL_LSB +: 2] = BCR_RST_INTVAL;
      rst_scale[BCR_CH4_SCALE_BIT]       = BCR_RST_SCALE;
      rst_mode   = BCR_DATA_ZERO;
      rst_mode[BCR_PSAVE_LSB +: 4] = BCR_RST_PSAVE;
      rst_mode[BCR_DSCG_LSB +: 4]  = fuse_in.discharge_enable;
      rst_latch  = BCR_DATA_ZERO;
      rst_latch[BCR_SHORT_LSB +: 4] = fuse_in.short_latchoff_enable;
      rst_latch[BCR_OVER_LSB +: 4]  =
         fuse_in.overvoltage_latchoff_enable;
      rst_freq   = BCR_DATA_ZERO;
      rst_freq[BCR_PH2_LSB +: 2]    = BCR_RST_PH2;
      rst_freq[BCR_PH3_LSB +: 2]    = BCR_RST_PH3;
      rst_freq[BCR_PH4_LSB +: 2]    = BCR_RST_PH4;
      rst_freq[BCR_CH1_HALF_BIT]    = fuse_in.ch1_half_freq;
      rst_freq[BCR_CH3_HALF_BIT]    = fuse_in.ch3_half_freq;
      rst_hiccup = BCR_DATA_ZERO;
      rst_hiccup[BCR_SYNC_OUT_BIT]  = fuse_in.sync_output_select;
   end

   // ----------------------------------------------------------------
   // Next register values and read data
   // ----------------------------------------------------------------
   always_comb
   begin
      nxt_ch23   = ch23_ff;
      nxt_ch4    = ch4_ff;
      nxt_scale  = scale_ff;
      nxt_mode   = mode_ff;
      nxt_latch  = latch_ff;
      nxt_freq   = freq_ff;
      nxt_hiccup = hiccup_ff;
      flag_clear = '0;
      nxt_rvalid = req_in.rd_strobe;
      nxt_rdata  = rdata_ff;
      if (wr_hit(req_in, BCR_OFF_CH23_VOLT))
         nxt_ch23 = req_in.wdata;
      if (wr_hit(req_in, BCR_OFF_CH4_VOLT))
         nxt_ch4 = req_in.wdata;
      if (wr_hit(req_in, BCR_OFF_SCALING))
         nxt_scale = req_in.wdata;
      if (wr_hit(req_in, BCR_OFF_MODE_DSCG))
         nxt_mode = req_in.wdata;
      if (wr_hit(req_in, BCR_OFF_LATCHOFF))
         nxt_latch = req_in.wdata;
      if (wr_hit(req_in, BCR_OFF_FREQ_PHASE))
         nxt_freq = req_in.wdata;
      if (wr_hit(req_in, BCR_OFF_HICCUP_SYNC))
         nxt_hiccup = req_in.wdata;
      if (wr_hit(req_in, BCR_OFF_LATCH_STAT))
         flag_clear = req_in.wdata[N_CH-1:0];
      if (req_in.rd_strobe)
      begin
         unique case (req_in.addr)
            BCR_OFF_CH23_VOLT:   nxt_rdata = ch23_ff;
            BCR_OFF_CH4_VOLT:    nxt_rdata = ch4_ff;
            BCR_OFF_SCALING:     nxt_rdata = scale_ff;
            BCR_OFF_MODE_DSCG:   nxt_rdata = mode_ff;
            BCR_OFF_LATCHOFF:    nxt_rdata = latch_ff;
            BCR_OFF_FREQ_PHASE:  nxt_rdata = freq_ff;
            BCR_OFF_HICCUP_SYNC: nxt_rdata = hiccup_ff;
            BCR_OFF_LATCH_STAT:
               nxt_rdata = {{(8-N_CH){1'b0}}, flags};
            default:             nxt_rdata = BCR_DATA_ZERO;
         endcase
      end
   end

   // Registers; defaults reload only under power-on reset
   always_ff @(posedge clk_sys_in)
   begin
      if (reset_in)
      begin
         ch23_ff   <= rst_ch23;
         ch4_ff    <= rst_ch4;
         scale_ff  <= rst_scale;
         mode_ff   <= rst_mode;
         latch_ff  <= rst_latch;
         freq_ff   <= rst_freq;
         hiccup_ff <= rst_hiccup;
         rdata_ff  <= BCR_DATA_ZERO;
         rvalid_ff <= 1'b0;
      end
      else
      begin
         ch23_ff   <= nxt_ch23;
         ch4_ff    <= nxt_ch4;
         scale_ff  <= nxt_scale;
         mode_ff   <= nxt_mode;
         latch_ff  <= nxt_latch;
         freq_ff   <= nxt_freq;
         hiccup_ff <= nxt_hiccup;
         rdata_ff  <= nxt_rdata;
         rvalid_ff <= nxt_rvalid;
      end
   end

   // ----------------------------------------------------------------
   // Mode gating: pin low forces auto mode everywhere unless sync output select is set
   // ----------------------------------------------------------------
   assign mode_bits_active = mode_pin_in || hiccup_ff[BCR_SYNC_OUT_BIT];
   assign psave_sel = mode_ff[BCR_PSAVE_LSB +: N_CH];

   // Per-channel effective power-save mode
   generate
      for (genvar g = 0; g < N_CH; g++)
      begin : g_mode
         assign cfg_out.power_save_active[g] =
            mode_bits_active ? psave_sel[g] : 1'b1;
      end
   endgenerate

   // ----------------------------------------------------------------
   // Field outputs
   // ----------------------------------------------------------------
   assign cfg_out.ch2_volt_code      = ch23_ff[BCR_CH2_VOLT_LSB +: 3];
   assign cfg_out.ch4_volt_code      = ch4_ff[BCR_CH4_VOLT_LSB +: 5];
   assign cfg_out.ch1_scaling_enable = scale_ff[BCR_CH1_SCALE_BIT];
   assign cfg_out.ch4_scaling_enable = scale_ff[BCR_CH4_SCALE_BIT];
   assign cfg_out.discharge_enable   = mode_ff[BCR_DSCG_LSB +: 4];
   assign cfg_out.overvoltage_latchoff_enable =
      latch_ff[BCR_OVER_LSB +: 4];
   assign cfg_out.short_latchoff_enable =
      latch_ff[BCR_SHORT_LSB +: 4];
   assign cfg_out.ch3_half_freq      = freq_ff[BCR_CH3_HALF_BIT];
   assign cfg_out.ch1_half_freq      = freq_ff[BCR_CH1_HALF_BIT];
   assign cfg_out.ch2_phase_offset   = freq_ff[BCR_PH2_LSB +: 2];
   assign cfg_out.ch3_phase_offset   = freq_ff[BCR_PH3_LSB +: 2];
   assign cfg_out.ch4_phase_offset   = freq_ff[BCR_PH4_LSB +: 2];
   assign cfg_out.sync_output_select = hiccup_ff[BCR_SYNC_OUT_BIT];
   assign rdata_out  = rdata_ff;
   assign rvalid_out = rvalid_ff;
   assign latchoff_flag_out = flags;

   // ----------------------------------------------------------------
   // Latch-off status flags
   // ----------------------------------------------------------------
   bcr_latch_flags #(
      .N_CH            (N_CH)
   ) u_flags (
      .clk_sys_in      (clk_sys_in),
      .reset_in        (reset_in),
      .over_fault_in   (over_fault_in),
      .short_fault_in  (short_fault_in),
      .over_enable_in  (latch_ff[BCR_OVER_LSB +: N_CH]),
      .short_enable_in (latch_ff[BCR_SHORT_LSB +: N_CH]),
      .clear_in        (flag_clear),
      .flag_out        (flags)
   );

   // ----------------------------------------------------------------
   // Scaling step timers for channels 1 and 4
   // ----------------------------------------------------------------
   bcr_step_timer u_ch1_step (
      .clk_sys_in    (clk_sys_in),
      .reset_in      (reset_in),
      .enable_in     (scale_ff[BCR_CH1_SCALE_BIT]),
      .interval_in   (scale_ff[BCR_CH1_INTVAL_LSB +: 2]),
      .step_tick_out (ch1_step_tick_out)
   );

   bcr_step_timer u_ch4_step (
      .clk_sys_in    (clk_sys_in),
      .reset_in      (reset_in),
      .enable_in     (scale_ff[BCR_CH4_SCALE_BIT]),
      .interval_in   (scale_ff[BCR_CH4_INTVAL_LSB +: 2]),
      .step_tick_out (ch4_step_tick_out)
   );

endmodule : bcr_config_regs
`default_nettype wire

/* File: tb/bcr_config_regs_properties.sv */
/*
 Property checker for the buck channel configuration register bank.
 Assumes it is bound to bcr_config_regs and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module bcr_config_regs_properties
   import bcr_pkg::*;
#(
   parameter int N_CH = 4
)
(
   // Clock and reset
   input  wire logic               clk_sys_in,
   input  wire logic               reset_in,
   // Watched ports
   input  wire bcr_pkg::bcr_fuse_t fuse_in,
   input  wire bcr_pkg::bcr_req_t  req_in,
   input  wire logic [7:0]         rdata_out,
   input  wire logic               rvalid_out,
   input  wire logic               mode_pin_in,
   input  wire logic [N_CH-1:0]    over_fault_in,
   input  wire logic [N_CH-1:0]    short_fault_in,
   input  wire bcr_pkg::bcr_cfg_t  cfg_out,
   input  wire logic [N_CH-1:0]    latchoff_flag_out,
   input  wire logic               ch1_step_tick_out,
   input  wire logic               ch4_step_tick_out
);
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (reset_in);
   logic [N_CH-1:0] set_mask;
   // Channels whose fault is enabled this cycle
   assign set_mask = (over_fault_in & cfg_out.overvoltage_latchoff_enable)
                   | (short_fault_in & cfg_out.short_latchoff_enable);
   sequence s_wr(logic [7:0] off);
      req_in.wr_strobe && req_in.addr == off;
   endsequence
   sequence s_rd(logic [7:0] off);
      req_in.rd_strobe && req_in.addr == off;
   endsequence
   property p_defaults;
      @(posedge clk_sys_in) disable iff (1'b0)
      reset_in |=> cfg_out.ch2_volt_code == $past(fuse_in.ch2_volt_code)
         && cfg_out.ch4_volt_code == $past(fuse_in.ch4_volt_code)
         && {cfg_out.ch4_phase_offset, cfg_out.ch3_phase_offset,
             cfg_out.ch2_phase_offset} == 6'h22
         && latchoff_flag_out == '0 && !cfg_out.ch1_scaling_enable;
   endproperty
   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   a_read_answer: assert property (req_in.rd_strobe |=> rvalid_out)
      else $error("read not answered next cycle");
   a_unmapped_zero: assert property (s_rd(8'h55) |=> rdata_out == 8'h00)
      else $error("unmapped read not zero");
   a_ch2_code: assert property (s_wr(BCR_OFF_CH23_VOLT) |=>
      cfg_out.ch2_volt_code == $past(req_in.wdata[2:0]))
      else $error("channel 2 code not taken");
   a_ch4_code: assert property (s_wr(BCR_OFF_CH4_VOLT) |=>
      cfg_out.ch4_volt_code == $past(req_in.wdata[4:0]))
      else $error("channel 4 code not taken");
   a_scaling_enables: assert property (s_wr(BCR_OFF_SCALING) |=>
      {cfg_out.ch4_scaling_enable, cfg_out.ch1_scaling_enable}
      == {$past(req_in.wdata[6]), $past(req_in.wdata[2])})
      else $error("scaling enables wrong");
   a_psave_bits: assert property (s_wr(BCR_OFF_MODE_DSCG) ##1
      (mode_pin_in || cfg_out.sync_output_select)
      |-> cfg_out.power_save_active == $past(req_in.wdata[3:0]))
      else $error("power save bits not applied");
   a_mode_low: assert property (!mode_pin_in &&
      !cfg_out.sync_output_select |-> cfg_out.power_save_active == 4'hf)
      else $error("mode pin low did not force auto");
   a_discharge_bits: assert property (s_wr(BCR_OFF_MODE_DSCG) |=>
      cfg_out.discharge_enable == $past(req_in.wdata[7:4]))
      else $error("discharge enables wrong");
   a_latch_enables: assert property (s_wr(BCR_OFF_LATCHOFF) |=>
      {cfg_out.overvoltage_latchoff_enable, cfg_out.short_latchoff_enable}
      == $past(req_in.wdata))
      else $error("latch-off enables wrong");
   a_freq_phase: assert property (s_wr(BCR_OFF_FREQ_PHASE) |=>
      {cfg_out.ch3_half_freq, cfg_out.ch1_half_freq,
       cfg_out.ch4_phase_offset, cfg_out.ch3_phase_offset,
       cfg_out.ch2_phase_offset} == $past(req_in.wdata))
      else $error("frequency or phase wrong");
   a_flag_set: assert property (set_mask != '0 |=>
      (latchoff_flag_out & $past(set_mask)) == $past(set_mask))
      else $error("latch-off flag not set");
   a_reset_defaults: assert property (p_defaults)
      else $error("reset defaults wrong");
   a_tick_spacing: assert property ($rose(ch1_step_tick_out) |=>
      !ch1_step_tick_out [*8])
      else $error("step ticks too close");
endmodule : bcr_config_regs_properties
bind bcr_config_regs bcr_config_regs_properties #(.N_CH(N_CH))
   bcr_config_regs_properties_i (.clk_sys_in, .reset_in, .fuse_in, .req_in,
   .rdata_out, .rvalid_out, .mode_pin_in, .over_fault_in, .short_fault_in,
   .cfg_out, .latchoff_flag_out, .ch1_step_tick_out, .ch4_step_tick_out);
`default_nettype wire

/* File: tb/bcr_host_model.sv */
/*
 Host model on the register port: one-cycle write and read strobes.
 Assumes reads are answered by rvalid one cycle after the take.
*/
`timescale 1ns/1ps
`default_nettype none
module bcr_host_model
   import bcr_pkg::*;
(
   // Clock
   input  wire logic              clk_sys_in,
   // Register port
   output var bcr_pkg::bcr_req_t  req_out,
   input  wire logic [7:0]        rdata_in,
   input  wire logic              rvalid_in
);
   initial req_out = '0;
   // One strobe, then strobes dropped and address and data released to inverted values
   task automatic issue(input logic wr, input logic [7:0] a, d);
      @(posedge clk_sys_in);
      req_out <= '{wr, !wr, a, d};
      @(posedge clk_sys_in);
      req_out <= '{1'b0, 1'b0, ~a, ~d};
   endtask : issue
   task automatic write_reg(input logic [7:0] a, d);
      issue(1'b1, a, d);
   endtask : write_reg
   // Read; ok stays low when no answer within four cycles
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d,
                           output logic ok);
      ok = 1'b0;
      d = 8'h00;
      issue(1'b0, a, 8'h00);
      for (int i = 0; i < 4 && !ok; i++)
      begin
         @(posedge clk_sys_in);
         ok = (rvalid_in === 1'b1);
         d = rdata_in;
      end
   endtask : read_reg
endmodule : bcr_host_model
`default_nettype wire

/* File: tb/tb_bcr_config_regs.sv */
/*
 Testbench for the configuration register bank: defaults, table of writes
 with readback, then mode pin, latch-off flags, step ticks and defaults after a second reset.
 Assumes the host model and the bound property checker.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_bcr_config_regs;
   import bcr_pkg::*;
   logic        clk_sys_in = 1'b0;
   logic        reset_in   = 1'b1;
   logic        mode_pin   = 1'b1;
   logic [3:0]  over_f     = 4'h0;
   logic [3:0]  short_f    = 4'h0;
   bcr_fuse_t   fuse       = '{3'h5, 5'h1b, 4'h9, 4'h6, 4'ha, 1'b1,
                                1'b0, 1'b0};
   bcr_req_t    req;
   bcr_cfg_t    cfg;
   logic [7:0]  rdata, got;
   logic        rvalid, ok, tick1, tick4;
   logic [3:0]  flags;
   int          n_mismatch = 0;
   int          n_tests    = 0;
   int          steps [4]  = '{BCR_STEP0_CYC, BCR_STEP1_CYC,
                               BCR_STEP2_CYC, BCR_STEP3_CYC};
   logic [15:0] rows [16]  = '{16'h0307, 16'h0308, 16'h0400, 16'h04ff,
      16'h0500, 16'h0555, 16'h05aa, 16'h05ff, 16'h065a, 16'h06a5,
      16'h07c3, 16'h073c, 16'h0800, 16'h0855, 16'h08aa, 16'h08ff};
   always #50 clk_sys_in = ~clk_sys_in;
   bcr_config_regs bcr_config_regs_i (.clk_sys_in, .reset_in,
      .fuse_in(fuse), .req_in(req), .rdata_out(rdata), .rvalid_out(rvalid),
      .mode_pin_in(mode_pin), .over_fault_in(over_f),
      .short_fault_in(short_f), .cfg_out(cfg), .latchoff_flag_out(flags),
      .ch1_step_tick_out(tick1), .ch4_step_tick_out(tick4));
   bcr_host_model bcr_host_model_i (.clk_sys_in, .req_out(req),
      .rdata_in(rdata), .rvalid_in(rvalid));
   task automatic finish_test();
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : finish_test
   task automatic fail_out(input string m);
      $display("unexpected at %0t: %s", $time, m);
      n_mismatch++;
      finish_test();
   endtask : fail_out
   task automatic chk(input logic [15:0] g, e);
      n_tests++;
      if (g !== e)
         $display("unexpected at %0t: got %h exp %h", $time, g, e);
      if (g !== e)
         n_mismatch++;
   endtask : chk
   task automatic rd(input logic [7:0] a, e);
      bcr_host_model_i.read_reg(a, got, ok);
      if (!ok)
         fail_out("no read answer");
      chk({8'h00, got}, {8'h00, e});
   endtask : rd
   // Readback of fuse and fixed defaults
   task automatic defaults(input bcr_fuse_t f);
      rd(8'h03, {5'h00, f.ch2_volt_code});
      rd(8'h04, {3'h0, f.ch4_volt_code});
      rd(8'h05, 8'h00);
      rd(8'h06, {f.discharge_enable, 4'h0});
      rd(8'h07, {f.overvoltage_latchoff_enable, f.short_latchoff_enable});
      rd(8'h08, {f.ch3_half_freq, f.ch1_half_freq, 6'h22});
   endtask : defaults
   // Cycles between two ticks of one channel
   task automatic gap(input logic sel4, input int exp);
      int n, t;
      n = 0;
      t = 0;
      for (int i = 0; i < 1400 && t < 2; i++)
      begin
         @(posedge clk_sys_in);
         if ((sel4 ? tick4 : tick1) === 1'b1)
            t++;
         if (t == 1)
            n++;
      end
      if (t < 2)
         fail_out("no step tick");
      chk(16'(n), 16'(exp));
   endtask : gap
   initial
   begin
      repeat (4) @(posedge clk_sys_in);
      reset_in <= 1'b0;
      defaults(fuse);
      rd(8'h55, 8'h00);
      bcr_host_model_i.write_reg(8'h55, 8'h3c);
      rd(8'h55, 8'h00);
      foreach (rows[i])
      begin
         bcr_host_model_i.write_reg(rows[i][15:8], rows[i][7:0]);
         rd(rows[i][15:8], rows[i][7:0]);
      end
      // Mode pin and sync output select
      bcr_host_model_i.write_reg(8'h06, 8'h05);
      @(posedge clk_sys_in);
      chk(16'(cfg.power_save_active), 16'h5);
      mode_pin <= 1'b0;
      repeat (2) @(posedge clk_sys_in);
      chk(16'(cfg.power_save_active), 16'hf);
      bcr_host_model_i.write_reg(8'h0a, 8'h80);
      @(posedge clk_sys_in);
      chk(16'(cfg.power_save_active), 16'h5);
      // Enabled fault latches, disabled one does not
      bcr_host_model_i.write_reg(8'h07, 8'h20);
      over_f <= 4'h2;
      short_f <= 4'h1;
      repeat (3) @(posedge clk_sys_in);
      chk(16'(flags), 16'h2);
      rd(8'h0c, 8'h02);
      // Clear refused while the fault persists
      bcr_host_model_i.write_reg(8'h0c, 8'h02);
      @(posedge clk_sys_in);
      chk(16'(flags), 16'h2);
      over_f <= 4'h0;
      short_f <= 4'h0;
      bcr_host_model_i.write_reg(8'h0c, 8'h02);
      @(posedge clk_sys_in);
      chk(16'(flags), 16'h0);
      // Every step interval on both channels
      for (int c = 0; c < 4; c++)
      begin
         bcr_host_model_i.write_reg(8'h05, 8'h44 | 8'(c) | 8'(c << 4));
         gap(1'b0, steps[c]);
         gap(1'b1, steps[c]);
      end
      // Second reset loads the fuse values present then
      @(posedge clk_sys_in);
      fuse <= ~fuse;
      reset_in <= 1'b1;
      repeat (4) @(posedge clk_sys_in);
      reset_in <= 1'b0;
      defaults(fuse);
      finish_test();
   end
endmodule : tb_bcr_config_regs
`default_nettype wire
